//--- exec_defines.vh
// Constants for the six-instruction execution datapath.
// Assumes inclusion by bare name from the datapath module only.
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH

// ----------------------------------------------------------------------
// Operation codes presented on op_i
// ----------------------------------------------------------------------
`define OP_NONE                 3'h0
`define OP_REG_MINUS_WORK       3'h1
`define OP_IMM_MINUS_WORK       3'h2
`define OP_NIBBLE_EXCHANGE      3'h3
`define OP_TABLE_JUMP           3'h4
`define OP_REG_EXCLUSIVE_OR     3'h5
`define OP_IMM_EXCLUSIVE_OR     3'h6

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define FILE_ADDR_MAX           6'h3F
`define DEST_WORK               1'h0
`define DEST_FILE               1'h1
`define RESET_WORK              8'h00
`define RESET_PC                12'h000
`define PC_LOW_MSB              7
`define PC_PAGE_LSB             10

`endif

//--- sub_swap_xor_table_exec.v
// Execution datapath for subtract, nibble swap, XOR and table look-up.
// Assumes fetch/decode presents one operation per clock with the file
// register value already read; file write-back is done by the caller.
// Assumes the caller loads pc_o into its program counter while pc_load_o
// is high; the flags live here, so the three flag inputs are not read.
//
// Contract
// (RULE_01) File register minus working register, two's complement, all three flags, one cycle.
// (RULE_02) Destination bit 0 sends the result to the working register, 1 to the file register.
// (RULE_03) Immediate minus working register goes to the working register, all flags, one cycle.
// (RULE_04) Nibble swap exchanges the halves of the file register, no flags, one cycle.
// (RULE_05) Table step adds working register to PC low byte, keeps PC 9..8, loads page bits.
// (RULE_06) File register XOR working register updates zero only and follows the destination bit.
// (RULE_07) Immediate XOR working register goes to the working register, zero only, one cycle.
// (RULE_08) Zero flag marks a zero result and carry flags mean no borrow on subtraction.
`timescale 1ns/1ps
`include "exec_defines.vh"

module sub_swap_xor_table_exec (
   input  wire        sys_clk_i,
   input  wire        sys_rst_i,
   input  wire [2:0]  op_i,
   input  wire [5:0]  file_addr_i,
   input  wire [7:0]  file_data_i,
   input  wire        dest_i,
   input  wire [7:0]  imm_i,
   input  wire [1:0]  page_select_bits_i,
   input  wire [11:0] pc_i,
   input  wire        carry_i,
   input  wire        half_carry_flag_i,
   input  wire        zero_i,
   output reg  [7:0]  working_register_o,
   output reg  [11:0] pc_o,
   output reg         pc_load_o,
   output reg         file_we_o,
   output reg  [5:0]  file_addr_o,
   output reg  [7:0]  file_wdata_o,
   output reg         carry_o,
   output reg         half_carry_flag_o,
   output reg         zero_o
);

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------

   // Subtraction a - b as a + ~b + 1; bit 8 is carry, meaning no borrow.
   function [8:0] sub9;
      input [7:0] a;
      input [7:0] b;
      begin
         sub9 = {1'b0, a} + {1'b0, ~b} + 9'h001;
      end
   endfunction

   // Half-carry out of bit 3 for a - b, meaning no borrow from bit 4.
   function sub_half;
      input [7:0] a;
      input [7:0] b;
      reg   [4:0] s;
      begin
         s = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
         sub_half = s[4];
      end
   endfunction

   // Routes a result to the file register when the destination bit is set.
   function to_file;
      input d;
      begin
         to_file = (d == `DEST_FILE);
      end
   endfunction

   // Routes a result to the working register when the destination bit is clear.
   function to_work;
      input d;
      begin
         to_work = (d == `DEST_WORK);
      end
   endfunction

   // Zero test on an 8-bit result, shared by every flag-setting operation.
   function is_zero;
      input [7:0] v;
      begin
         is_zero = (v == 8'h00);
      end
   endfunction

   // Carry out of bit 3 for the table step, which adds rather than borrows.
   function add_half;
      input [3:0] a;
      input [3:0] b;
      reg   [4:0] s;
      begin
         s        = {1'b0, a} + {1'b0, b};
         add_half = s[4];
      end
   endfunction

   // ----------------------------------------------------------------------
   // Combinational result selection
   // ----------------------------------------------------------------------
   reg [8:0]  next_sum;
   reg [7:0]  next_result;
   reg        next_c;
   reg        next_half;
   reg        next_z;
   reg        next_to_file;
   reg        next_to_work;
   reg [11:0] next_pc;
   reg        next_pc_load;
   reg [8:0]  pc_sum;
   wire [7:0] swapped;

   // Nibble exchange wiring: result bit k takes file bit (k + 4) mod 8.
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1) begin : g_swap
         assign swapped[k] = file_data_i[(k + 4) % 8];
      end
   endgenerate

   // Picks the result, flags and destination for the current operation.
   // Flags that an operation does not name keep their value, as codes 0 and 7 do.
   always @* begin
      next_sum     = 9'h000;
      pc_sum       = {1'b0, pc_i[`PC_LOW_MSB:0]} + {1'b0, working_register_o};
      next_result  = 8'h00;
      next_c       = carry_o;
      next_half    = half_carry_flag_o;
      next_z       = zero_o;
      next_to_file = 1'b0;
      next_to_work = 1'b0;
      next_pc      = pc_o;
      next_pc_load = 1'b0;
      case (op_i)
         `OP_REG_MINUS_WORK: begin
            // RULE_01 file minus work
            next_sum     = sub9(file_data_i, working_register_o);
            next_result  = next_sum[7:0];
            next_c       = next_sum[8];
            next_half    = sub_half(file_data_i, working_register_o);
            // RULE_08 zero on result
            next_z       = is_zero(next_sum[7:0]);
            // RULE_02 destination bit routing
            next_to_file = to_file(dest_i);
            next_to_work = to_work(dest_i);
         end
         `OP_IMM_MINUS_WORK: begin
            // RULE_03 immediate minus work
            next_sum     = sub9(imm_i, working_register_o);
            next_result  = next_sum[7:0];
            next_c       = next_sum[8];
            next_half    = sub_half(imm_i, working_register_o);
            next_z       = is_zero(next_sum[7:0]);
            next_to_work = 1'b1;
         end
         `OP_NIBBLE_EXCHANGE: begin
            // RULE_04 swap, flags kept
            next_result  = swapped;
            next_to_file = to_file(dest_i);
            next_to_work = to_work(dest_i);
         end
         `OP_TABLE_JUMP: begin
            // RULE_05 table program-counter step
            // Carry and half-carry here are those of the addition, not a borrow.
            next_pc      = {page_select_bits_i, pc_i[9:8], pc_sum[7:0]};
            next_pc_load = 1'b1;
            next_c       = pc_sum[8];
            next_half    = add_half(pc_i[3:0], working_register_o[3:0]);
            next_z       = is_zero(pc_sum[7:0]);
         end
         `OP_REG_EXCLUSIVE_OR: begin
            // RULE_06 file XOR, zero only
            next_result  = file_data_i ^ working_register_o;
            next_z       = is_zero(next_result);
            next_to_file = to_file(dest_i);
            next_to_work = to_work(dest_i);
         end
         `OP_IMM_EXCLUSIVE_OR: begin
            // RULE_07 immediate XOR, zero only
            next_result  = imm_i ^ working_register_o;
            next_z       = is_zero(next_result);
            next_to_work = 1'b1;
         end
         default: begin
            next_result  = 8'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Registered state and outputs
   // ----------------------------------------------------------------------

   // Commits every result at the clock edge, so each operation takes one cycle.
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         working_register_o <= `RESET_WORK;
         pc_o               <= `RESET_PC;
         pc_load_o          <= 1'b0;
         file_we_o          <= 1'b0;
         file_addr_o        <= 6'h00;
         file_wdata_o       <= 8'h00;
         carry_o            <= 1'b0;
         half_carry_flag_o  <= 1'b0;
         zero_o             <= 1'b0;
      end else begin
         if (next_to_work) begin
            working_register_o <= next_result;
         end
         pc_o              <= next_pc;
         pc_load_o         <= next_pc_load;
         file_we_o         <= next_to_file;
         file_addr_o       <= file_addr_i;
         // The result shows every cycle; only file_we_o says it is meant.
         file_wdata_o      <= next_result;
         carry_o           <= next_c;
         half_carry_flag_o <= next_half;
         zero_o            <= next_z;
      end
   end

endmodule

//--- exec_rules_chk.sv
// Concurrent checks on the execution datapath outputs.
// Assumes binding to the datapath top; one clock, synchronous reset.
`timescale 1ns/1ps
module exec_rules_chk (
   input wire logic        sys_clk_i,
   input wire logic        sys_rst_i,
   input wire logic [2:0]  op_i,
   input wire logic [7:0]  file_data_i,
   input wire logic        dest_i,
   input wire logic [7:0]  imm_i,
   input wire logic [1:0]  page_select_bits_i,
   input wire logic [11:0] pc_i,
   input wire logic [7:0]  working_register_o,
   input wire logic [11:0] pc_o,
   input wire logic        pc_load_o,
   input wire logic        file_we_o,
   input wire logic [7:0]  file_wdata_o,
   input wire logic        carry_o,
   input wire logic        zero_o
);
   // ------------------------------------------------------------
   // One-cycle result checks per operation
   // ------------------------------------------------------------
   // All checks share the core clock and reset.
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_sub_file; op_i == 3'h1 && dest_i |=> file_we_o &&
      file_wdata_o == $past(file_data_i) - $past(working_register_o); endproperty
   a_sub_file: assert property (p_sub_file) else $error("sub to file wrong");
   property p_dest_work; op_i == 3'h1 && !dest_i |=> !file_we_o &&
      working_register_o == $past(file_data_i) - $past(working_register_o); endproperty
   a_dest_work: assert property (p_dest_work) else $error("sub to work wrong");
   property p_sub_imm; op_i == 3'h2 |=>
      working_register_o == $past(imm_i) - $past(working_register_o); endproperty
   a_sub_imm: assert property (p_sub_imm) else $error("imm sub wrong");
   property p_swap; op_i == 3'h3 |=> carry_o == $past(carry_o) && zero_o == $past(zero_o) &&
      file_wdata_o == {$past(file_data_i[3:0]), $past(file_data_i[7:4])}; endproperty
   a_swap: assert property (p_swap) else $error("swap wrong");
   property p_table; op_i == 3'h4 |=> pc_load_o && pc_o == {$past(page_select_bits_i),
      $past(pc_i[9:8]), $past(pc_i[7:0]) + $past(working_register_o)}; endproperty
   a_table: assert property (p_table) else $error("table pc wrong");
   property p_xor_file; op_i == 3'h5 |=> carry_o == $past(carry_o) &&
      zero_o == (file_wdata_o == 8'h00) &&
      file_wdata_o == ($past(file_data_i) ^ $past(working_register_o)); endproperty
   a_xor_file: assert property (p_xor_file) else $error("xor flags wrong");
   property p_xor_imm; op_i == 3'h6 |=>
      working_register_o == ($past(imm_i) ^ $past(working_register_o)); endproperty
   a_xor_imm: assert property (p_xor_imm) else $error("imm xor wrong");
   property p_flags; op_i == 3'h2 |=> zero_o == (working_register_o == 8'h00) &&
      carry_o == ($past(imm_i) >= $past(working_register_o)); endproperty
   a_flags: assert property (p_flags) else $error("sub flags wrong");
endmodule

//--- sub_swap_xor_table_exec_bench.sv
// Self-checking bench for the execution datapath.
// Assumes the datapath and its checker are compiled alongside.
`timescale 1ns/1ps
module sub_swap_xor_table_exec_bench;
   // ------------------------------------------------------------
   // Stimulus, reference model and checks
   // ------------------------------------------------------------
   reg         clk = 1'b0, rst = 1'b1, d = 1'b0;
   reg  [2:0]  op = 3'h0, fl = 3'h0, ef = 3'h0;
   reg  [5:0]  fa = 6'h00;
   reg  [7:0]  fd = 8'h00, imm = 8'h00, ew = 8'h00, r, src;
   reg  [1:0]  page = 2'h0;
   reg  [11:0] pc = 12'h000;
   reg  [63:0] rv = 64'h0;
   wire [7:0]  w, wd;
   wire [11:0] pco;
   wire [5:0]  ao;
   wire        ld, we, c, h, z;
   integer     err_total = 0, total_checks = 0, cyc = 0, i;
   sub_swap_xor_table_exec sub_swap_xor_table_exec_i (.sys_clk_i(clk), .sys_rst_i(rst),
      .op_i(op), .file_addr_i(fa), .file_data_i(fd), .dest_i(d), .imm_i(imm),
      .page_select_bits_i(page), .pc_i(pc), .carry_i(fl[2]), .half_carry_flag_i(fl[1]),
      .zero_i(fl[0]), .working_register_o(w), .pc_o(pco), .pc_load_o(ld), .file_we_o(we),
      .file_addr_o(ao), .file_wdata_o(wd), .carry_o(c), .half_carry_flag_o(h), .zero_o(z));
   // Clock at 40 MHz and a hang limit.
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc >= 5000) begin
         err_total = err_total + 1;
         final_report;
      end
   end
   task chk(input string nm, input [11:0] e, input [11:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // Expected 8-bit result of an operation on source s and working value wv.
   function [7:0] exp_result(input [2:0] o, input [7:0] s, input [7:0] wv);
      begin
         if (o == 3'h3)
            exp_result = {s[3:0], s[7:4]};
         else if (o >= 3'h5)
            exp_result = s ^ wv;
         else
            exp_result = s - wv;
      end
   endfunction
   // Drives one operation, predicts its effect, then checks after the edge.
   task apply(input [2:0] o, input [7:0] a, input dd, input [7:0] im, input [11:0] p,
              input [1:0] g);
      reg [8:0] s;
      reg       wr;
      begin
         op = o;
         fd = a;
         d = dd;
         imm = im;
         pc = p;
         page = g;
         {fa, fl} = rv[42:34];
         src = (o == 3'h2 || o == 3'h6) ? im : a;
         s = p[7:0] + ew;
         wr = (o == 3'h1 || o == 3'h3 || o == 3'h5);
         r = exp_result(o, src, ew);
         if (o == 3'h1 || o == 3'h2) ef = {src >= ew, src[3:0] >= ew[3:0], r == 8'h00};
         if (o == 3'h4) ef = {s[8], (p[3:0] + ew[3:0]) > 15, s[7:0] == 8'h00};
         if (o == 3'h5 || o == 3'h6) ef[0] = (r == 8'h00);
         if (o == 3'h2 || o == 3'h6 || (wr && !dd)) ew = r;
         @(posedge clk);
         #2;
         chk("work", {4'h0, ew}, {4'h0, w});
         chk("flags", {9'h0, ef}, {9'h0, c, h, z});
         chk("we", {11'h0, wr && dd}, {11'h0, we});
         if (wr && dd) chk("wdata", {4'h0, r}, {4'h0, wd});
         chk("addr", {6'h00, fa}, {6'h00, ao});
         chk("load", {11'h0, o == 3'h4}, {11'h0, ld});
         if (o == 3'h4) chk("pc", {g, p[9:8], s[7:0]}, pco);
      end
   endtask
   task final_report;
      begin
         if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // Corner cases first, a mid-run reset, then random operations.
   initial begin
      i = $urandom(48);
      repeat (6) @(posedge clk);
      #2 rst = 1'b0;
      apply(3'h6, 8'h00, 1'b0, 8'h03, 12'h000, 2'h0);
      apply(3'h1, 8'h05, 1'b1, 8'h00, 12'h000, 2'h0);
      apply(3'h4, 8'h00, 1'b0, 8'h00, 12'h1FE, 2'h2);
      apply(3'h2, 8'h00, 1'b0, 8'h00, 12'h000, 2'h0);
      apply(3'h1, 8'hFD, 1'b0, 8'h00, 12'h3FF, 2'h3);
      apply(3'h3, 8'hA5, 1'b1, 8'h00, 12'h000, 2'h0);
      apply(3'h7, 8'hA5, 1'b1, 8'h00, 12'h000, 2'h0);
      rst = 1'b1;
      @(posedge clk);
      #2 rst = 1'b0;
      ew = 8'h00;
      ef = 3'h0;
      for (i = 0; i < 2000; i = i + 1) begin
         rv = {$urandom, $urandom};
         apply(rv[2:0], rv[10:3], rv[11], rv[19:12], rv[31:20], rv[33:32]);
      end
      final_report;
   end
endmodule
bind sub_swap_xor_table_exec exec_rules_chk exec_rules_chk_i (.sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i), .op_i(op_i), .file_data_i(file_data_i), .dest_i(dest_i),
   .imm_i(imm_i), .page_select_bits_i(page_select_bits_i), .pc_i(pc_i),
   .working_register_o(working_register_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
   .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .carry_o(carry_o), .zero_o(zero_o));
